/* File: shared/input_line_pkg.sv */
/*
 * constants, field layouts, register map and types for the input line channel.
 * assumes a 25 MHz module clock and an apb slave with 8-bit byte addresses.
 */
package input_line_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    localparam int TICK_NS        = 100000;                     // 0.1 ms width unit
    localparam int TICK_CYCLES    = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GATE_NS        = 1000000000;                 // one second gate
    localparam int GATE_TICKS     = GATE_NS / TICK_NS;
    localparam int TICK_CNT_BITS  = 12;
    localparam int GATE_CNT_BITS  = 16;
    localparam int WIDTH_BITS     = 16;
    localparam int COUNT_BITS     = 32;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_BITS     = 8;
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_CMD      = 8'h04;
    localparam logic [7:0]  ADDR_LOW_W    = 8'h08;
    localparam logic [7:0]  ADDR_HIGH_W   = 8'h0c;
    localparam logic [7:0]  ADDR_STATUS   = 8'h10;
    localparam logic [7:0]  ADDR_COUNT    = 8'h14;
    localparam logic [7:0]  ADDR_FREQ     = 8'h18;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h1c;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h20;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int MODE_BITS      = 3;
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_INVERT    = 3;
    localparam int CTRL_FILTER    = 4;
    localparam int CTRL_RETAIN    = 5;
    localparam int CMD_COMMIT     = 0;
    localparam int CMD_START      = 1;
    localparam int CMD_STOP       = 2;
    localparam int CMD_CLEAR      = 3;
    localparam int CMD_CLR_LATCH  = 4;
    localparam int STAT_LEVEL     = 0;
    localparam int STAT_LATCH     = 1;
    localparam int STAT_RUN       = 2;
    localparam int STAT_MODE_LSB  = 4;
    localparam int IRQ_BITS       = 3;
    localparam int IRQ_LATCH      = 0;
    localparam int IRQ_FREQ       = 1;
    localparam int IRQ_WRAP       = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] WIDTH_RESET   = 16'h0001;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_LEVEL      = 3'b000,
        MODE_COUNTER    = 3'b001,
        MODE_RISE_LATCH = 3'b010,
        MODE_FALL_LATCH = 3'b011,
        MODE_FREQUENCY  = 3'b100
    } input_line_function_select_type;

    // a written code is usable only if it names one of the five functions
    function automatic logic legal_mode(input logic [MODE_BITS-1:0] code);
        legal_mode = (code <= 3'b100);
    endfunction

endpackage

/* File: tb/digital_input_channel_modes_tb.sv */
/*
 * self-checking bench for the input line channel, driven over apb.
 * assumes a tick of 4 clocks and a gate of 5 ticks to keep runs short.
 */
`timescale 1ns/1ps
module digital_input_channel_modes_tb;
    import input_line_pkg::*;
    // ----------
    // signals and instances
    // ----------
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, count_to_keep, rdata;
    logic        pready, pslverr, input_line, count_keep_enable, input_line_level_indicator, irq, err;
    logic        retain_at_power_on = 1'b1, en = 1'b0, rest = 1'b0;
    logic [31:0] kept_count = 32'hffff_fffe;
    int          errors = 0, tests_run = 0;
    // 25 MHz clock
    always #20 clk = ~clk;
    input_line_channel #(.TICK_CYCLES_P(4), .GATE_TICKS_P(5)) u_input_line_channel (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_line(input_line), .retain_at_power_on(retain_at_power_on),
        .kept_count(kept_count), .count_to_keep(count_to_keep), .count_keep_enable(count_keep_enable),
        .input_line_level_indicator(input_line_level_indicator), .irq(irq));
    field_source u_field_source (.clk(clk), .en(en), .rest(rest), .line(input_line));
    // ----------
    // tasks
    // ----------
    task automatic final_report;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            $display("BAD %0t no pready", $time);
            final_report();
        end
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // n whole pulses, then settling time
    task automatic pulse(input int n);
        en <= 1'b1;
        cyc(4 * n);
        en <= 1'b0;
        cyc(10);
    endtask
    // ----------
    // main sequence
    // ----------
    initial begin
        cyc(2);
        nrst <= 1'b1;
        cyc(1);
        rd(ADDR_COUNT, 32'hffff_fffe);
        check(32'(count_keep_enable), 32'h1);
        rd(ADDR_LOW_W, 32'h1);
        rd(ADDR_CTRL, 32'h20);
        apb(1'b0, 8'h24, 32'h0);
        check(32'(err), 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h4);
        apb(1'b1, ADDR_CTRL, 32'h21);
        apb(1'b1, ADDR_CMD, 32'h3);
        pulse(3);
        rd(ADDR_COUNT, 32'h1);
        check(32'(irq), 32'h1);
        rd(ADDR_IRQ_STAT, 32'h4);
        apb(1'b1, ADDR_IRQ_STAT, 32'h4);
        check(32'(irq), 32'h0);
        apb(1'b1, ADDR_CMD, 32'h4);
        pulse(2);
        rd(ADDR_COUNT, 32'h1);
        apb(1'b1, ADDR_CMD, 32'h2);
        pulse(2);
        rd(ADDR_COUNT, 32'h3);
        apb(1'b1, ADDR_CMD, 32'hc);
        rd(ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h8);
        apb(1'b1, ADDR_CMD, 32'h1);
        cyc(8);
        rd(ADDR_STATUS, 32'h1);
        // rise latch sets going up, fall latch going down
        for (int m = 2; m < 4; m++) begin
            apb(1'b1, ADDR_CTRL, 32'(m));
            apb(1'b1, ADDR_CMD, 32'h1);
            cyc(8);
            apb(1'b1, ADDR_CMD, 32'h10);
            rest <= 1'b1;
            cyc(10);
            rd(ADDR_STATUS, 32'(m * 16 + (m == 2 ? 3 : 1)));
            rest <= 1'b0;
            cyc(10);
            rd(ADDR_STATUS, 32'(m * 16 + 2));
            apb(1'b1, ADDR_CMD, 32'h10);
            rd(ADDR_STATUS, 32'(m * 16));
        end
        apb(1'b1, ADDR_CTRL, 32'h4);
        rd(ADDR_STATUS, 32'h30);
        apb(1'b1, ADDR_CMD, 32'h1);
        en <= 1'b1;
        cyc(60);
        rd(ADDR_FREQ, 32'h5);
        en <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h10);
        apb(1'b1, ADDR_CMD, 32'h1);
        apb(1'b1, ADDR_LOW_W, 32'h2);
        apb(1'b1, ADDR_HIGH_W, 32'h2);
        cyc(20);
        rest <= 1'b1;
        cyc(3);
        rest <= 1'b0;
        cyc(20);
        rd(ADDR_STATUS, 32'h0);
        rest <= 1'b1;
        cyc(30);
        rd(ADDR_STATUS, 32'h1);
        nrst <= 1'b0;
        retain_at_power_on <= 1'b0;
        cyc(2);
        nrst <= 1'b1;
        cyc(1);
        rd(ADDR_COUNT, 32'h0);
        final_report();
    end
endmodule

/* File: tb/field_source.sv */
/*
 * far-side model of one field input pin.
 * assumes the bench moves en and rest just after a rising clock edge.
 */
`timescale 1ns/1ps
module field_source #(
    parameter int HALF = 2
) (
    // clock
    input  wire logic clk,
    // control from the bench
    input  wire logic en,
    input  wire logic rest,
    // field pin
    output logic      line
);
    // ----------
    // square wave while enabled, a steady rest level otherwise
    // ----------
    int cnt = 0;
    // a wave always starts from the rest level, so n periods give n whole pulses
    always @(posedge clk) begin
        if (!en) begin
            line <= rest;
            cnt  <= 0;
        end else if (cnt == HALF - 1) begin
            line <= ~line;
            cnt  <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* File: tb/input_line_assertions.sv */
/*
 * port-level checks for the input line channel.
 * assumes it is bound to input_line_channel and sees only its ports.
 */
`timescale 1ns/1ps
module input_line_assertions (
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // field and retention
    input wire logic        input_line,
    input wire logic        retain_at_power_on,
    input wire logic [31:0] kept_count,
    input wire logic [31:0] count_to_keep,
    input wire logic        count_keep_enable,
    // status
    input wire logic        input_line_level_indicator,
    input wire logic        irq
);
    // ----------
    // one clock domain, so one default clocking and reset
    // ----------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // boot edge loads the kept count only when retention is asked for
    boot_count_a: assert property ($rose(nrst) |=>
        count_to_keep == ($past(retain_at_power_on) ? $past(kept_count) : 32'h0)) else $error("boot count wrong");
    keep_flag_a: assert property ($rose(nrst) |=>
        count_keep_enable == $past(retain_at_power_on)) else $error("retain flag wrong");
    // the count only steps by one, wraps or clears; two cycles skip the boot load
    count_step_a: assert property ($past(nrst, 2) && count_to_keep != $past(count_to_keep) |->
        count_to_keep == $past(count_to_keep) + 32'h1 || count_to_keep == 32'h0) else $error("count jumped");
    count_cause_a: assert property ($past(nrst, 2) && count_to_keep == $past(count_to_keep) + 32'h1 |->
        input_line_level_indicator && !$past(input_line_level_indicator)) else $error("count w/o rise");
    // zero-wait slave: readback path answers in the first access cycle
    ready_fast_a: assert property (psel && !penable |=> pready) else $error("pready late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
endmodule

bind input_line_channel input_line_assertions
    u_input_line_assertions (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_line(input_line), .retain_at_power_on(retain_at_power_on), .kept_count(kept_count),
    .count_to_keep(count_to_keep), .count_keep_enable(count_keep_enable),
    .input_line_level_indicator(input_line_level_indicator), .irq(irq));

/* File: verilog/input_line_channel.sv */
/*
 * one conditioned digital input line with level, counter, edge latch and
 * frequency functions, apb register file and a masked level interrupt.
 * assumes a 25 MHz clk, synchronous active-low nrst at power-on, an apb
 * master on the same clock and a non-volatile store for the count.
 */
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps

// What this block does
// - one function active at a time; a new function applies only on commit.
// - invert setting complements the sampled level before all downstream logic.
// - filter can be switched per channel; when off the level passes through.
// - filtered level changes only after persisting its programmed low or high width.
// - counter function counts each pulse; host can read the count.
// - count advances only while started; stop freezes without clearing.
// - clear command sets the count to zero.
// - with retention the count resumes from the stored value at power-on.
// - rising latch function sets latch status on low-to-high until host clears.
// - falling latch function sets latch status on high-to-low until host clears.
// - frequency function measures input frequency; host can read the result.
module input_line_channel #(
    parameter int TICK_CYCLES_P = input_line_pkg::TICK_CYCLES,
    parameter int GATE_TICKS_P  = input_line_pkg::GATE_TICKS
) (
    // clock and reset
    input  wire logic                                clk,
    input  wire logic                                nrst,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [input_line_pkg::ADDR_BITS-1:0] paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // field input
    input  wire logic                                input_line,
    // power-on retention
    input  wire logic                                retain_at_power_on,
    input  wire logic [input_line_pkg::COUNT_BITS-1:0] kept_count,
    output logic      [input_line_pkg::COUNT_BITS-1:0] count_to_keep,
    output logic                                     count_keep_enable,
    // status
    output logic                                     input_line_level_indicator,
    output logic                                     irq
);
    import input_line_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [MODE_BITS-1:0]           pend_mode;
        logic                           invert;
        logic                           filt_en;
        logic                           retain;
        input_line_function_select_type mode;
        logic                           running;
        logic [WIDTH_BITS-1:0]          low_w;
        logic [WIDTH_BITS-1:0]          high_w;
        logic [COUNT_BITS-1:0]          count;
        logic [COUNT_BITS-1:0]          freq;
        logic [COUNT_BITS-1:0]          freq_acc;
        logic [GATE_CNT_BITS-1:0]       gate;
        logic [TICK_CNT_BITS-1:0]       tick_cnt;
        logic                           prev_lvl;
        logic                           latch;
        logic [IRQ_BITS-1:0]            irq_stat;
        logic [IRQ_BITS-1:0]            irq_mask;
        logic                           booted;
        logic [31:0]                    prdata;
        logic                           pready;
        logic                           pslverr;
        logic                           irq;
        logic                           indicator;
    } channel_state_type;

    channel_state_type r;
    channel_state_type next_r;

    logic synced;
    logic conditioned;
    logic tick;

    // ------------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------------
    input_line_sync u_sync (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (input_line),
        .level (synced)
    );

    // inversion sits ahead of the filter so widths refer to the active level
    input_line_filter u_filter (
        .clk        (clk),
        .nrst       (nrst),
        .tick       (tick),
        .enable     (r.filt_en),
        .low_width  (r.low_w),
        .high_width (r.high_w),
        .level_in   (synced ^ r.invert),
        .level_out  (conditioned)
    );

    // 0.1 ms enable pulse from the clock divider
    assign tick = (r.tick_cnt == TICK_CNT_BITS'(TICK_CYCLES_P - 1));

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    logic                   access;
    logic                   wr;
    logic                   setup;
    logic                   rise;
    logic                   fall;
    logic                   cmd_commit;
    logic                   cmd_start;
    logic                   cmd_stop;
    logic                   cmd_clear;
    logic                   cmd_clr_latch;
    logic [IRQ_BITS-1:0]    irq_set;
    logic [IRQ_BITS-1:0]    irq_clr;
    logic [COUNT_BITS-1:0]  acc_inc;
    logic                   gate_end;

    always_comb begin
        next_r        = r;
        setup         = psel && !penable;
        access        = psel && penable && r.pready;
        wr            = access && pwrite;
        rise          = conditioned && !r.prev_lvl;
        fall          = !conditioned && r.prev_lvl;
        cmd_commit    = wr && (paddr == ADDR_CMD) && pwdata[CMD_COMMIT];
        cmd_start     = wr && (paddr == ADDR_CMD) && pwdata[CMD_START];
        cmd_stop      = wr && (paddr == ADDR_CMD) && pwdata[CMD_STOP];
        cmd_clear     = wr && (paddr == ADDR_CMD) && pwdata[CMD_CLEAR];
        cmd_clr_latch = wr && (paddr == ADDR_CMD) && pwdata[CMD_CLR_LATCH];
        irq_set       = '0;
        irq_clr       = '0;
        acc_inc       = r.freq_acc + {{(COUNT_BITS-1){1'b0}}, rise};
        gate_end      = tick && (r.gate == GATE_CNT_BITS'(GATE_TICKS_P - 1));

        // divider and edge history
        next_r.tick_cnt  = tick ? '0 : r.tick_cnt + TICK_CNT_BITS'(1);
        next_r.prev_lvl  = conditioned;
        next_r.indicator = conditioned;

        // configuration writes
        if (wr && paddr == ADDR_CTRL) begin
            next_r.pend_mode = pwdata[CTRL_MODE_LSB +: MODE_BITS];
            next_r.invert    = pwdata[CTRL_INVERT];
            next_r.filt_en   = pwdata[CTRL_FILTER];
            next_r.retain    = pwdata[CTRL_RETAIN];
        end
        if (wr && paddr == ADDR_LOW_W) begin
            next_r.low_w = pwdata[WIDTH_BITS-1:0];
        end
        if (wr && paddr == ADDR_HIGH_W) begin
            next_r.high_w = pwdata[WIDTH_BITS-1:0];
        end
        if (wr && paddr == ADDR_IRQ_MASK) begin
            next_r.irq_mask = pwdata[IRQ_BITS-1:0];
        end
        if (wr && paddr == ADDR_IRQ_STAT) begin
            irq_clr = pwdata[IRQ_BITS-1:0];
        end

        // pending function becomes active only on commit; illegal codes are ignored
        if (cmd_commit && legal_mode(r.pend_mode)) begin
            next_r.mode = input_line_function_select_type'(r.pend_mode);
        end

        // start and stop; stop wins if both are written together
        if (cmd_start) begin
            next_r.running = 1'b1;
        end
        if (cmd_stop) begin
            next_r.running = 1'b0;
        end

        // function logic on the conditioned level
        unique case (r.mode)
            MODE_LEVEL: begin
            end
            MODE_COUNTER: begin
                if (rise && r.running) begin
                    next_r.count = r.count + COUNT_BITS'(1);
                    if (&r.count) begin
                        irq_set[IRQ_WRAP] = 1'b1;
                    end
                end
            end
            MODE_RISE_LATCH: begin
                if (rise) begin
                    irq_set[IRQ_LATCH] = 1'b1;
                end
            end
            MODE_FALL_LATCH: begin
                if (fall) begin
                    irq_set[IRQ_LATCH] = 1'b1;
                end
            end
            MODE_FREQUENCY: begin
                if (gate_end) begin
                    next_r.freq     = acc_inc;
                    next_r.freq_acc = '0;
                    irq_set[IRQ_FREQ] = 1'b1;
                end else begin
                    next_r.freq_acc = acc_inc;
                end
            end
            default: begin
            end
        endcase

        // gate restarts whenever the frequency function is not active
        if (r.mode != MODE_FREQUENCY) begin
            next_r.gate     = '0;
            next_r.freq_acc = '0;
        end else if (gate_end) begin
            next_r.gate = '0;
        end else if (tick) begin
            next_r.gate = r.gate + GATE_CNT_BITS'(1);
        end

        // clear overrides a same-cycle count
        if (cmd_clear) begin
            next_r.count = '0;
        end

        // latch: set wins over clear; edges only ever set it
        if (cmd_clr_latch) begin
            next_r.latch = 1'b0;
        end
        if (irq_set[IRQ_LATCH]) begin
            next_r.latch = 1'b1;
        end

        // sticky interrupt status: a new event beats a same-cycle clear
        next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);

        // first cycle after reset release loads the count from the store, or zero without retention
        if (!r.booted) begin
            next_r.booted = 1'b1;
            next_r.retain = retain_at_power_on;
            next_r.count  = retain_at_power_on ? kept_count : ZERO_WORD;
        end

        // apb: answer is prepared at setup and released after the access edge
        next_r.pready = setup;
        if (setup) begin
            next_r.pslverr = 1'b0;
            next_r.prdata  = ZERO_WORD;
            unique case (paddr)
                ADDR_CTRL: begin
                    next_r.prdata[CTRL_MODE_LSB +: MODE_BITS] = r.pend_mode;
                    next_r.prdata[CTRL_INVERT]                = r.invert;
                    next_r.prdata[CTRL_FILTER]                = r.filt_en;
                    next_r.prdata[CTRL_RETAIN]                = r.retain;
                end
                ADDR_CMD: begin
                end
                ADDR_LOW_W: begin
                    next_r.prdata[WIDTH_BITS-1:0] = r.low_w;
                end
                ADDR_HIGH_W: begin
                    next_r.prdata[WIDTH_BITS-1:0] = r.high_w;
                end
                ADDR_STATUS: begin
                    next_r.prdata[STAT_LEVEL]                  = r.indicator;
                    next_r.prdata[STAT_LATCH]                  = r.latch;
                    next_r.prdata[STAT_RUN]                    = r.running;
                    next_r.prdata[STAT_MODE_LSB +: MODE_BITS]  = r.mode;
                end
                ADDR_COUNT: begin
                    next_r.prdata = r.count;
                end
                ADDR_FREQ: begin
                    next_r.prdata = r.freq;
                end
                ADDR_IRQ_STAT: begin
                    next_r.prdata[IRQ_BITS-1:0] = r.irq_stat;
                end
                ADDR_IRQ_MASK: begin
                    next_r.prdata[IRQ_BITS-1:0] = r.irq_mask;
                end
                default: begin
                    next_r.pslverr = 1'b1;                    // unmapped or misaligned
                end
            endcase
        end else if (access) begin
            next_r.pslverr = 1'b0;
            next_r.prdata  = ZERO_WORD;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r        <= '0;
            r.mode   <= MODE_LEVEL;
            r.low_w  <= WIDTH_RESET;
            r.high_w <= WIDTH_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------------
    assign prdata                     = r.prdata;
    assign pready                     = r.pready;
    assign pslverr                    = r.pslverr;
    assign count_to_keep              = r.count;
    assign count_keep_enable          = r.retain;
    assign input_line_level_indicator = r.indicator;
    assign irq                        = r.irq;

endmodule

/* File: verilog/input_line_filter.sv */
/*
 * glitch filter with separate minimum low and high widths in tick units.
 * assumes tick is a one-cycle pulse every 0.1 ms from the same clock.
 */
`timescale 1ns/1ps
module input_line_filter (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // configuration
    input  wire logic        tick,
    input  wire logic        enable,
    input  wire logic [15:0] low_width,
    input  wire logic [15:0] high_width,
    // signal
    input  wire logic        level_in,
    output logic             level_out
);
    import input_line_pkg::*;

    typedef struct packed {
        logic                  accepted;
        logic [WIDTH_BITS-1:0] persist;
    } filter_state_type;

    filter_state_type      r;
    filter_state_type      next_r;
    logic [WIDTH_BITS-1:0] target_width;
    logic [WIDTH_BITS-1:0] persist_inc;

    // a width of zero acts as one tick; phase of the tick gives up to one tick of jitter
    always_comb begin
        next_r       = r;
        target_width = level_in ? high_width : low_width;
        persist_inc  = r.persist + WIDTH_BITS'(1);
        if (!enable) begin
            next_r.accepted = level_in;
            next_r.persist  = '0;
        end else if (level_in == r.accepted) begin
            next_r.persist  = '0;
        end else if (tick) begin
            if (persist_inc >= target_width) begin
                next_r.accepted = level_in;
                next_r.persist  = '0;
            end else begin
                next_r.persist  = persist_inc;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level_out = r.accepted;

endmodule

/* File: verilog/input_line_sync.sv */
/*
 * three-stage synchroniser with agreement check for the field pin.
 * assumes the pin is asynchronous to clk; output is a registered level.
 */
`timescale 1ns/1ps
module input_line_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // pin side
    input  wire logic pin,
    // logic side
    output logic      level
);
    import input_line_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_type;

    sync_state_type r;
    sync_state_type next_r;

    // s1 is read only by s2; the level moves once s2 and s3 agree
    always_comb begin
        next_r       = r;
        next_r.s1    = pin;
        next_r.s2    = r.s1;
        next_r.s3    = r.s2;
        if (r.s2 == r.s3) begin
            next_r.level = r.s3;
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign level = r.level;

endmodule
